// ### rtl/bridge_audio_cfg_link_status.sv
// Audio configuration and link/input status register bank of the bridge
`timescale 1ns/1ps
module bridge_audio_cfg_link_status (
	// Clock and reset
	input  wire logic                                clock,
	input  wire logic                                rst_n,
	// Register access from the serial control bus
	input  wire logic [7:0]                          reg_addr,
	input  wire logic                                reg_write,
	input  wire logic [7:0]                          reg_wdata,
	input  wire logic                                reg_read,
	output logic [7:0]                               reg_rdata,
	output logic                                     reg_rvalid,
	// Controls held elsewhere in the bridge
	input  wire logic                                external_controller_select,
	input  wire logic [1:0]                          audio_mode,
	input  wire logic                                freq_detector_source_select,
	// Observed conditions
	input  wire bridge_audio_pkg::link_conditions_t  conditions,
	input  wire bridge_audio_pkg::audio_watch_t      watch,
	// Audio path controls
	output logic                                     tdm_converter_enable,
	output logic                                     converter_clock_select,
	output logic                                     i2s_output_enable,
	output logic                                     audio_fifo_reset
);
	// ----------------------------------------------------------------
	// Register state
	// ----------------------------------------------------------------
	logic [7:0] audio_configuration;
	logic [7:0] link_and_input_status;
	logic [7:0] next_audio_configuration;
	logic [7:0] next_link_and_input_status;
	logic [7:0] next_reg_rdata;
	logic       next_reg_rvalid;
	logic       next_tdm_converter_enable;
	logic       next_i2s_output_enable;
	logic       next_audio_fifo_reset;
	logic       tx_locked;
	logic       freq_settled;

	logic [bridge_audio_pkg::WATCH_WIDTH-1:0] watch_value [bridge_audio_pkg::WATCH_COUNT];
	logic [bridge_audio_pkg::WATCH_COUNT-1:0] watch_changed;
	logic [bridge_audio_pkg::WATCH_COUNT-1:0] watch_enable;

	// ----------------------------------------------------------------
	// Change watchers
	// ----------------------------------------------------------------
	assign watch_value[bridge_audio_pkg::WATCH_TYPE] = 40'(watch.audio_type);
	assign watch_value[bridge_audio_pkg::WATCH_AIF]  = 40'(watch.audio_infoframe_sum);
	assign watch_value[bridge_audio_pkg::WATCH_AVI]  = 40'(watch.video_infoframe_sum);
	assign watch_value[bridge_audio_pkg::WATCH_ACR]  = {watch.clock_regen_n, watch.clock_regen_cts};

	// type, audio frame, video frame, N/CTS enables
	assign watch_enable[bridge_audio_pkg::WATCH_TYPE] =
		audio_configuration[bridge_audio_pkg::RESET_ON_TYPE_BIT];
	assign watch_enable[bridge_audio_pkg::WATCH_AIF] =
		audio_configuration[bridge_audio_pkg::RESET_ON_AIF_BIT];
	assign watch_enable[bridge_audio_pkg::WATCH_AVI] =
		audio_configuration[bridge_audio_pkg::RESET_ON_AVI_BIT];
	assign watch_enable[bridge_audio_pkg::WATCH_ACR] =
		audio_configuration[bridge_audio_pkg::RESET_ON_ACR_BIT];

	genvar w;
	generate
		for (w = 0; w < bridge_audio_pkg::WATCH_COUNT; w++) begin : g_watch
			value_change_detect #(
				.WIDTH   (bridge_audio_pkg::WATCH_WIDTH)
			) u_detect (
				.clock   (clock),
				.rst_n   (rst_n),
				.value   (watch_value[w]),
				.changed (watch_changed[w])
			);
		end
	endgenerate

	// ----------------------------------------------------------------
	// Next-state logic
	// ----------------------------------------------------------------
	// lock requires valid input and settled mode
	assign tx_locked = conditions.tx_active && conditions.remote_locked &&
		conditions.input_detected && conditions.mode_settled;
	assign freq_settled = freq_detector_source_select ? conditions.freq_settled_pll :
		conditions.freq_settled_raw;

	always_comb begin
		next_audio_configuration = audio_configuration;
		if (reg_write && reg_addr == bridge_audio_pkg::AUDIO_CONFIGURATION_ADDR) begin
			next_audio_configuration = reg_wdata & bridge_audio_pkg::AUDIO_CFG_WRITE_MASK;
		end

		next_link_and_input_status = bridge_audio_pkg::STATUS_RESET;
		next_link_and_input_status[bridge_audio_pkg::LINK_READY_BIT] = conditions.downlink_ready;
		next_link_and_input_status[bridge_audio_pkg::TX_LOCKED_BIT] = tx_locked;
		next_link_and_input_status[bridge_audio_pkg::PORT_MODE_HI:bridge_audio_pkg::PORT_MODE_LO] =
			tx_locked ? conditions.port_mode : bridge_audio_pkg::PORT_MODE_IDLE;
		next_link_and_input_status[bridge_audio_pkg::STREAM_VALID_BIT] =
			conditions.input_stream_valid;
		next_link_and_input_status[bridge_audio_pkg::PLL_LOCK_BIT] = conditions.pll_locked;
		next_link_and_input_status[bridge_audio_pkg::NO_CLOCK_BIT] = !conditions.clock_present;
		next_link_and_input_status[bridge_audio_pkg::FREQ_SETTLED_BIT] = freq_settled;

		// Unmapped addresses read as zero
		next_reg_rvalid = reg_read;
		next_reg_rdata  = reg_rdata;
		if (reg_read) begin
			case (reg_addr)
				bridge_audio_pkg::AUDIO_CONFIGURATION_ADDR: begin
					next_reg_rdata = audio_configuration;
				end
				bridge_audio_pkg::LINK_AND_INPUT_STATUS_ADDR: begin
					next_reg_rdata = link_and_input_status;
				end
				default: begin
					next_reg_rdata = 8'h00;
				end
			endcase
		end

		next_tdm_converter_enable = audio_configuration[bridge_audio_pkg::TDM_CONVERT_BIT];
		// I2S out, only in HDMI-only mode
		next_i2s_output_enable = audio_configuration[bridge_audio_pkg::HDMI_I2S_OUT_BIT] &&
			(audio_mode == bridge_audio_pkg::AUDIO_MODE_HDMI_ONLY);
		next_audio_fifo_reset = !external_controller_select && |(watch_changed & watch_enable);
	end

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			audio_configuration    <= bridge_audio_pkg::AUDIO_CFG_RESET;
			link_and_input_status  <= bridge_audio_pkg::STATUS_RESET;
			reg_rdata              <= 8'h00;
			reg_rvalid             <= 1'b0;
			tdm_converter_enable   <= 1'b0;
			converter_clock_select <= 1'b0;
			i2s_output_enable      <= 1'b0;
			audio_fifo_reset       <= 1'b0;
		end else begin
			audio_configuration    <= next_audio_configuration;
			link_and_input_status  <= next_link_and_input_status;
			reg_rdata              <= next_reg_rdata;
			reg_rvalid             <= next_reg_rvalid;
			tdm_converter_enable   <= next_tdm_converter_enable;
			// Audio is clocked from the converter whenever it is on
			converter_clock_select <= next_tdm_converter_enable;
			i2s_output_enable      <= next_i2s_output_enable;
			audio_fifo_reset       <= next_audio_fifo_reset;
		end
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);

	cfg_write_a: assert property (
		reg_write && reg_addr == bridge_audio_pkg::AUDIO_CONFIGURATION_ADDR
		|=> ##1 tdm_converter_enable == $past(reg_wdata[bridge_audio_pkg::TDM_CONVERT_BIT], 2)
		&& converter_clock_select == tdm_converter_enable)
		else $error("converter enable does not follow written bit");
	i2s_mode_gate_a: assert property (
		audio_mode != bridge_audio_pkg::AUDIO_MODE_HDMI_ONLY |=> !i2s_output_enable)
		else $error("I2S output driven outside HDMI-only mode");
	i2s_enable_a: assert property (
		audio_configuration[bridge_audio_pkg::HDMI_I2S_OUT_BIT] &&
		audio_mode == bridge_audio_pkg::AUDIO_MODE_HDMI_ONLY |=> i2s_output_enable)
		else $error("I2S output not enabled");
	reserved_zero_a: assert property (
		(audio_configuration & ~bridge_audio_pkg::AUDIO_CFG_WRITE_MASK) == 8'h00)
		else $error("reserved configuration bits not zero");
	fifo_type_a: assert property (
		watch_changed[bridge_audio_pkg::WATCH_TYPE] &&
		watch_enable[bridge_audio_pkg::WATCH_TYPE] && !external_controller_select
		|=> audio_fifo_reset)
		else $error("no FIFO reset on audio type change");
	fifo_cause_a: assert property (
		audio_fifo_reset |-> $past(|(watch_changed & watch_enable)))
		else $error("FIFO reset without an enabled change");
	ext_block_a: assert property (
		external_controller_select |=> !audio_fifo_reset)
		else $error("FIFO reset under external control");
	tx_gate_a: assert property (
		link_and_input_status[bridge_audio_pkg::TX_LOCKED_BIT]
		|-> $past(conditions.input_detected && conditions.mode_settled))
		else $error("transmit status without valid input and mode");
	port_idle_a: assert property (
		!link_and_input_status[bridge_audio_pkg::TX_LOCKED_BIT] |->
		link_and_input_status[bridge_audio_pkg::PORT_MODE_HI:bridge_audio_pkg::PORT_MODE_LO]
		== bridge_audio_pkg::PORT_MODE_IDLE)
		else $error("port mode shown while not locked");
	freq_source_a: assert property (
		freq_detector_source_select |=>
		link_and_input_status[bridge_audio_pkg::FREQ_SETTLED_BIT] ==
		$past(conditions.freq_settled_pll))
		else $error("frequency flag taken from wrong source");
	status_ro_a: assert property (
		reg_write && reg_addr == bridge_audio_pkg::LINK_AND_INPUT_STATUS_ADDR |=>
		link_and_input_status[bridge_audio_pkg::NO_CLOCK_BIT] ==
		!$past(conditions.clock_present))
		else $error("status changed by a write");
	read_cfg_a: assert property (
		reg_read && reg_addr == bridge_audio_pkg::AUDIO_CONFIGURATION_ADDR
		|=> reg_rvalid && reg_rdata == $past(audio_configuration))
		else $error("configuration read back wrong");

	fifo_reset_c: cover property (audio_fifo_reset);
	locked_c: cover property (link_and_input_status[bridge_audio_pkg::TX_LOCKED_BIT] &&
		link_and_input_status[bridge_audio_pkg::PORT_MODE_HI:bridge_audio_pkg::PORT_MODE_LO]
		== bridge_audio_pkg::PORT_REPLICATE);
	i2s_on_c: cover property (i2s_output_enable && tdm_converter_enable);
endmodule // bridge_audio_cfg_link_status

// ### rtl/bridge_audio_pkg.sv
// Register map, field layout and carrier types of the audio config / link status bank
package bridge_audio_pkg;

	// ----------------------------------------------------------------
	// Register offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] AUDIO_CONFIGURATION_ADDR   = 8'h55;
	localparam logic [7:0] LINK_AND_INPUT_STATUS_ADDR = 8'h5a;

	// ----------------------------------------------------------------
	// Audio configuration fields
	// ----------------------------------------------------------------
	localparam int         TDM_CONVERT_BIT       = 7;
	localparam int         HDMI_I2S_OUT_BIT      = 6;
	localparam int         RESET_ON_TYPE_BIT     = 3;
	localparam int         RESET_ON_AIF_BIT      = 2;
	localparam int         RESET_ON_AVI_BIT      = 1;
	localparam int         RESET_ON_ACR_BIT      = 0;
	localparam logic [7:0] AUDIO_CFG_WRITE_MASK  = 8'hcf;
	localparam logic [7:0] AUDIO_CFG_RESET       = 8'h0c;
	localparam logic [1:0] AUDIO_MODE_HDMI_ONLY  = 2'h0;

	// ----------------------------------------------------------------
	// Status fields
	// ----------------------------------------------------------------
	localparam int         LINK_READY_BIT        = 7;
	localparam int         TX_LOCKED_BIT         = 6;
	localparam int         PORT_MODE_HI          = 5;
	localparam int         PORT_MODE_LO          = 4;
	localparam int         STREAM_VALID_BIT      = 3;
	localparam int         PLL_LOCK_BIT          = 2;
	localparam int         NO_CLOCK_BIT          = 1;
	localparam int         FREQ_SETTLED_BIT      = 0;
	localparam logic [7:0] STATUS_RESET          = 8'h00;
	localparam logic [1:0] PORT_MODE_IDLE        = 2'h0;

	// ----------------------------------------------------------------
	// Change watch sources for the audio FIFO reset
	// ----------------------------------------------------------------
	localparam int         WATCH_COUNT           = 4;
	localparam int         WATCH_WIDTH           = 40;
	localparam int         WATCH_TYPE            = 0;
	localparam int         WATCH_AIF             = 1;
	localparam int         WATCH_AVI             = 2;
	localparam int         WATCH_ACR             = 3;

	typedef enum logic [1:0] {
		PORT_DUAL      = 2'h0,
		PORT_SINGLE_0  = 2'h1,
		PORT_SINGLE_1  = 2'h2,
		PORT_REPLICATE = 2'h3
	} port_mode_t;

	// Raw conditions from the link, receiver and frequency detector
	typedef struct packed {
		logic       downlink_ready;
		logic       tx_active;
		logic       remote_locked;
		logic       input_detected;
		logic       mode_settled;
		port_mode_t port_mode;
		logic       input_stream_valid;
		logic       pll_locked;
		logic       clock_present;
		logic       freq_settled_raw;
		logic       freq_settled_pll;
	} link_conditions_t;

	// Values watched for change by the audio FIFO reset logic
	typedef struct packed {
		logic [3:0]  audio_type;
		logic [7:0]  audio_infoframe_sum;
		logic [7:0]  video_infoframe_sum;
		logic [19:0] clock_regen_n;
		logic [19:0] clock_regen_cts;
	} audio_watch_t;

endpackage

// ### rtl/value_change_detect.sv
// Flags a change of a watched value once a first sample has been taken
`timescale 1ns/1ps
module value_change_detect #(
	parameter int WIDTH = 8
) (
	// Clock and reset
	input  wire logic             clock,
	input  wire logic             rst_n,
	// Watched value and result
	input  wire logic [WIDTH-1:0] value,
	output logic                  changed
);
	logic [WIDTH-1:0] last;
	logic             primed;
	logic [WIDTH-1:0] next_last;
	logic             next_primed;

	always_comb begin
		next_last   = value;
		next_primed = 1'b1;
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			last   <= '0;
			primed <= 1'b0;
		end else begin
			last   <= next_last;
			primed <= next_primed;
		end
	end

	// No compare before the first sample, so reset never looks like a change
	assign changed = primed && (value != last);
endmodule // value_change_detect

// ### tb/bridge_audio_cfg_link_status_tb.sv
// Self-checking bench for the audio configuration and link status bank
`timescale 1ns/1ps
module bridge_audio_cfg_link_status_tb;
	logic                               clock;
	logic                               rst_n;
	logic [7:0]                         reg_addr;
	logic                               reg_write;
	logic [7:0]                         reg_wdata;
	logic                               reg_read;
	logic [7:0]                         reg_rdata;
	logic                               reg_rvalid;
	logic                               external_controller_select;
	logic [1:0]                         audio_mode;
	logic                               freq_detector_source_select;
	bridge_audio_pkg::link_conditions_t conditions;
	bridge_audio_pkg::audio_watch_t     watch;
	logic                               tdm_converter_enable;
	logic                               converter_clock_select;
	logic                               i2s_output_enable;
	logic                               audio_fifo_reset;
	int                                 n_fail;
	int                                 n_checks;
	logic [7:0]                         audio_outs;

	assign audio_outs = {5'h00, tdm_converter_enable, converter_clock_select, i2s_output_enable};

	reg_host u_host (.clock(clock), .reg_addr(reg_addr), .reg_write(reg_write),
		.reg_wdata(reg_wdata), .reg_read(reg_read), .reg_rdata(reg_rdata),
		.reg_rvalid(reg_rvalid));

	bridge_audio_cfg_link_status u_dut (.clock(clock), .rst_n(rst_n), .reg_addr(reg_addr),
		.reg_write(reg_write), .reg_wdata(reg_wdata), .reg_read(reg_read),
		.reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
		.external_controller_select(external_controller_select), .audio_mode(audio_mode),
		.freq_detector_source_select(freq_detector_source_select),
		.conditions(conditions), .watch(watch), .tdm_converter_enable(tdm_converter_enable),
		.converter_clock_select(converter_clock_select),
		.i2s_output_enable(i2s_output_enable), .audio_fifo_reset(audio_fifo_reset));

	// ----------------------------------------------------------------
	// Checking helpers
	// ----------------------------------------------------------------
	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		n_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic read_check(input logic [7:0] addr, input logic [7:0] exp);
		logic [7:0] data;
		logic       valid;
		u_host.read_reg(addr, data, valid);
		check({7'h00, valid}, 8'h01);
		check(data, exp);
	endtask

	task automatic give_verdict();
		$display("checks %0d mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_reset();
		read_check(8'h55, 8'h0c);
		read_check(8'h5a, 8'h00);
		read_check(8'h33, 8'h00);
	endtask

	task automatic t_config();
		u_host.write_reg(8'h55, 8'hff);
		read_check(8'h55, 8'hcf);
		check(audio_outs, 8'h07);
		audio_mode = 2'h1;
		repeat (2) @(negedge clock);
		check({7'h00, i2s_output_enable}, 8'h00);
		audio_mode = 2'h0;
		u_host.write_reg(8'h55, 8'h40);
		repeat (2) @(negedge clock);
		check(audio_outs, 8'h01);
		u_host.write_reg(8'h5a, 8'hff);
		read_check(8'h5a, 8'h00);
	endtask

	task automatic t_status();
		bridge_audio_pkg::link_conditions_t c;
		// Built aside so the inputs change once per step
		for (int m = 0; m < 4; m++) begin
			c = '0;
			{c.downlink_ready, c.tx_active, c.remote_locked} = 3'h7;
			{c.input_detected, c.mode_settled} = 2'h3;
			c.port_mode = bridge_audio_pkg::port_mode_t'(m[1:0]);
			c.input_stream_valid = 1'b1;
			conditions = c;
			@(negedge clock);
			// Clock absent here, so the missing-clock bit reads one
			read_check(8'h5a, {2'h3, m[1:0], 4'ha});
		end
		conditions.mode_settled = 1'b0;
		@(negedge clock);
		read_check(8'h5a, 8'h8a);
		c = '0;
		c.pll_locked = 1'b1;
		c.clock_present = 1'b1;
		c.freq_settled_pll = 1'b1;
		conditions = c;
		@(negedge clock);
		read_check(8'h5a, 8'h04);
		freq_detector_source_select = 1'b1;
		@(negedge clock);
		read_check(8'h5a, 8'h05);
	endtask

	task automatic bump(input int k);
		case (k)
			0: watch.audio_type++;
			1: watch.audio_infoframe_sum++;
			2: watch.video_infoframe_sum++;
			3: watch.clock_regen_n++;
			default: watch.clock_regen_cts++;
		endcase
	endtask

	task automatic fifo_case(input int k, input logic [7:0] cfg, input logic ext,
			input logic exp);
		u_host.write_reg(8'h55, cfg);
		external_controller_select = ext;
		repeat (3) @(negedge clock);
		bump(k);
		@(negedge clock);
		check({7'h00, audio_fifo_reset}, {7'h00, exp});
		@(negedge clock);
		check({7'h00, audio_fifo_reset}, 8'h00);
	endtask

	// Reset in mid-run with stale watched values must not fake a change
	task automatic t_midreset();
		external_controller_select = 1'b0;
		u_host.write_reg(8'h55, 8'hcf);
		@(negedge clock);
		rst_n = 1'b0;
		@(negedge clock);
		check(audio_outs, 8'h00);
		rst_n = 1'b1;
		@(negedge clock);
		check({7'h00, audio_fifo_reset}, 8'h00);
		@(negedge clock);
		check({7'h00, audio_fifo_reset}, 8'h00);
		read_check(8'h55, 8'h0c);
		check(audio_outs, 8'h00);
	endtask

	task automatic t_fifo();
		logic [7:0] bit_of;
		for (int k = 0; k < 5; k++) begin
			bit_of = 8'h01 << ((k < 4) ? 3 - k : 0);
			fifo_case(k, bit_of, 1'b0, 1'b1);
			fifo_case(k, 8'h0f & ~bit_of, 1'b0, 1'b0);
			fifo_case(k, 8'h0f, 1'b1, 1'b0);
		end
	endtask

	// ----------------------------------------------------------------
	// Clock, reset, sequence and watchdog
	// ----------------------------------------------------------------
	initial begin
		clock = 1'b0;
		forever #2.5 clock = ~clock;
	end

	initial begin
		n_fail = 0;
		n_checks = 0;
		rst_n = 1'b0;
		external_controller_select = 1'b0;
		audio_mode = 2'h0;
		freq_detector_source_select = 1'b0;
		// Only the input clock present
		conditions = bridge_audio_pkg::link_conditions_t'(12'h004);
		watch = '0;
		repeat (10) @(negedge clock);
		rst_n = 1'b1;
		t_reset();
		t_config();
		t_status();
		t_fifo();
		t_midreset();
		give_verdict();
	end

	// Whole run is under two hundred cycles; this cuts a hang well beyond that
	initial begin
		#20000;
		n_fail++;
		give_verdict();
	end
endmodule // bridge_audio_cfg_link_status_tb

// ### tb/reg_host.sv
// Host model that reaches the register bank by byte writes and reads
`timescale 1ns/1ps
module reg_host (
	// Clock
	input  wire logic       clock,
	// Register strobes toward the bank
	output logic [7:0]      reg_addr,
	output logic            reg_write,
	output logic [7:0]      reg_wdata,
	output logic            reg_read,
	// Read answer
	input  wire logic [7:0] reg_rdata,
	input  wire logic       reg_rvalid
);
	initial begin
		reg_addr  = 8'h00;
		reg_write = 1'b0;
		reg_wdata = 8'h00;
		reg_read  = 1'b0;
	end

	// Strobes last one cycle; idle lines show the inverse so stale values never look valid
	task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
		@(negedge clock);
		reg_addr  = addr;
		reg_wdata = data;
		reg_write = 1'b1;
		@(negedge clock);
		reg_write = 1'b0;
		reg_addr  = ~addr;
		reg_wdata = ~data;
	endtask

	task automatic read_reg(input logic [7:0] addr, output logic [7:0] data,
			output logic valid);
		@(negedge clock);
		reg_addr = addr;
		reg_read = 1'b1;
		@(negedge clock);
		reg_read = 1'b0;
		reg_addr = ~addr;
		valid    = reg_rvalid;
		data     = reg_rdata;
	endtask
endmodule // reg_host
